// *** core/sdrd_host.v ***
// Contract
// RQ1 - A read starts with a read command carrying the start address as argument.
// RQ2 - The card answers every command with a normal response on the command line.
// RQ3 - Read data begins after the access delay from the command's last bit.
// RQ4 - Multi-block reads stream blocks back to back until a stop command.
// RQ5 - Data ends two card clocks after the stop command's end bit.
// RQ6 - At least 8 card clocks after a response or command before the next command.
// RQ7 - Access time comes from the field at bits 111 to 104, times 100 clocks.
// RQ8 - In one-bit mode the card holds data line one low to interrupt.
// RQ9 - In one-bit mode raise the interrupt while data line one is low.
// RQ10 - In four-bit mode sample data line one only in the interrupt period.
// RQ11 - The interrupt period falls only at each 512-byte block boundary.
// RQ12 - Read pause freezes the transfer counters while commands still go out.
// RQ13 - Leaving read pause resumes the transfer with the frozen values intact.
`include "sdrd_defs.vh"
module sdrd_host (
  input  wire        core_clk,
  input  wire        reset,
  input  wire        card_clk,
  input  wire        card_command_line_in,
  output reg         card_command_line_out,
  output reg         card_command_line_oe,
  input  wire [3:0]  card_data_in,
  input  wire        read_start,
  input  wire [31:0] read_address,
  input  wire        read_multi,
  input  wire        wide_bus,
  input  wire [7:0]  clocked_access_time_field,
  input  wire        read_pause_mode,
  input  wire        stop_request,
  output wire [7:0]  read_data,
  output wire        read_valid,
  input  wire        read_ready,
  output wire        card_clk_run,
  output wire        card_irq,
  output reg         busy,
  output reg         access_timeout,
  output reg         response_timeout
);
  localparam [4:0] C_IDLE = 5'h01;
  localparam [4:0] C_TX   = 5'h02;
  localparam [4:0] C_WAIT = 5'h04;
  localparam [4:0] C_RX   = 5'h08;
  localparam [4:0] C_GAP  = 5'h10;
  localparam [3:0] D_IDLE = 4'h1;
  localparam [3:0] D_WAIT = 4'h2;
  localparam [3:0] D_RX   = 4'h4;
  localparam [3:0] D_CRC  = 4'h8;

  reg  [2:0]  clk_sync;
  reg  [2:0]  cmd_sync;
  reg  [2:0]  dat_sync [0:3];
  reg         clk_lvl;
  reg         cmd_lvl;
  reg  [3:0]  dat_lvl;
  wire        clk_agree = (clk_sync[1] == clk_sync[2]);
  wire        rise = clk_agree & clk_sync[2] & ~clk_lvl;
  wire        fall = clk_agree & ~clk_sync[2] & clk_lvl;

  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : dat_sync_gen
      always @(posedge core_clk) begin
        if (reset) begin
          dat_sync[g] <= 3'h7;
          dat_lvl[g]  <= 1'b1;
        end else begin
          dat_sync[g] <= {dat_sync[g][1:0], card_data_in[g]};
          if (dat_sync[g][1] == dat_sync[g][2])
            dat_lvl[g] <= dat_sync[g][2];
        end
      end
    end
  endgenerate

  always @(posedge core_clk) begin
    if (reset) begin
      clk_sync <= 3'h0;
      cmd_sync <= 3'h7;
      clk_lvl  <= 1'b0;
      cmd_lvl  <= 1'b1;
    end else begin
      clk_sync <= {clk_sync[1:0], card_clk};
      cmd_sync <= {cmd_sync[1:0], card_command_line_in};
      if (clk_agree)
        clk_lvl <= clk_sync[2];
      if (cmd_sync[1] == cmd_sync[2])
        cmd_lvl <= cmd_sync[2];
    end
  end

  function [6:0] crc7_step;
    input [6:0] crc;
    input       bit_in;
    begin
      crc7_step = {crc[5:0], 1'b0} ^ ((bit_in ^ crc[6]) ? `SDRD_CRC7_POLY : 7'h00);
    end
  endfunction

  // Command engine.
  reg  [4:0]  cstate;
  reg  [39:0] cmd_shift;
  reg  [6:0]  cmd_crc;
  reg  [5:0]  cmd_bit;
  reg  [3:0]  gap_cnt;
  reg  [6:0]  rsp_wait;
  reg         cmd_is_stop;
  reg         stop_pending;
  reg         stop_sent;
  reg  [1:0]  stop_tail;
  reg  [3:0]  dstate;
  wire        gap_done = (gap_cnt >= `SDRD_GAP_MIN);

  always @(posedge core_clk) begin
    if (reset) begin
      cstate                <= C_IDLE;
      cmd_shift             <= 40'h0;
      cmd_crc               <= 7'h00;
      cmd_bit               <= 6'h00;
      gap_cnt               <= `SDRD_GAP_MIN;
      rsp_wait              <= 7'h00;
      cmd_is_stop           <= 1'b0;
      stop_pending          <= 1'b0;
      stop_sent             <= 1'b0;
      card_command_line_out <= 1'b1;
      card_command_line_oe  <= 1'b0;
      response_timeout      <= 1'b0;
    end else begin
      stop_sent <= 1'b0;
      if (stop_request && read_multi && busy && !cmd_is_stop)
        stop_pending <= 1'b1;
      if (rise && gap_cnt != 4'hf)
        gap_cnt <= gap_cnt + 4'h1;
      case (cstate)
        C_IDLE: begin
          if (read_start && !busy && gap_done) begin
            cmd_shift <= {2'b01, (read_multi ? `SDRD_CMD_READ_MULTI :
                                   `SDRD_CMD_READ_SINGLE), read_address}; // [RQ1]
            cmd_is_stop      <= 1'b0;
            response_timeout <= 1'b0;
            cmd_bit          <= 6'h00;
            cmd_crc          <= 7'h00;
            cstate           <= C_TX;
          end else if (stop_pending && gap_done) begin // [RQ6] [RQ12]
            cmd_shift    <= {2'b01, `SDRD_CMD_STOP, 32'h0};
            cmd_is_stop  <= 1'b1;
            stop_pending <= 1'b0;
            cmd_bit      <= 6'h00;
            cmd_crc      <= 7'h00;
            cstate       <= C_TX;
          end
        end
        C_TX: begin
          if (fall) begin
            card_command_line_oe <= 1'b1;
            if (cmd_bit < `SDRD_CMD_CRC_FIRST) begin
              card_command_line_out <= cmd_shift[39];
              cmd_crc   <= crc7_step(cmd_crc, cmd_shift[39]);
              cmd_shift <= {cmd_shift[38:0], 1'b0};
            end else if (cmd_bit < `SDRD_CMD_LAST_BIT) begin
              card_command_line_out <= cmd_crc[6];
              cmd_crc <= {cmd_crc[5:0], 1'b0};
            end else begin
              card_command_line_out <= 1'b1;
            end
            cmd_bit <= cmd_bit + 6'h01;
            if (cmd_bit == `SDRD_CMD_BITS) begin
              card_command_line_oe  <= 1'b0;
              card_command_line_out <= 1'b1;
              stop_sent <= cmd_is_stop;
              gap_cnt   <= 4'h0; // [RQ6]
              rsp_wait  <= 7'h00;
              cstate    <= C_WAIT;
            end
          end
        end
        C_WAIT: begin
          if (rise) begin
            if (!cmd_lvl) begin // [RQ2]
              cmd_bit <= 6'h01;
              cstate  <= C_RX;
            end else if (rsp_wait == `SDRD_RSP_LIMIT) begin
              response_timeout <= 1'b1;
              gap_cnt          <= 4'h0;
              cstate           <= C_GAP;
            end else begin
              rsp_wait <= rsp_wait + 7'h01;
            end
          end
        end
        C_RX: begin
          if (rise) begin
            cmd_bit <= cmd_bit + 6'h01;
            if (cmd_bit == `SDRD_RSP_LAST_BIT) begin
              gap_cnt <= 4'h0; // [RQ6]
              cstate  <= C_GAP;
            end
          end
        end
        C_GAP: begin
          if (gap_done)
            cstate <= C_IDLE;
        end
        default: cstate <= C_IDLE;
      endcase
    end
  end

  // Two-entry buffer; a full buffer gates the card clock so no byte is dropped.
  reg  [7:0]  buf_mem [0:1];
  reg         buf_wr;
  reg         buf_rd;
  reg  [1:0]  buf_cnt;
  reg         byte_push;
  reg  [7:0]  byte_shift;
  wire        buf_in_ready = (buf_cnt != 2'h2);
  wire        buf_pop = read_valid & read_ready;
  assign read_valid   = (buf_cnt != 2'h0);
  assign read_data    = buf_mem[buf_rd];
  assign card_clk_run = (buf_cnt == 2'h0) | (buf_cnt == 2'h1 & ~byte_push);

  always @(posedge core_clk) begin
    if (reset) begin
      buf_wr     <= 1'b0;
      buf_rd     <= 1'b0;
      buf_cnt    <= 2'h0;
      buf_mem[0] <= 8'h00;
      buf_mem[1] <= 8'h00;
    end else begin
      if (byte_push && buf_in_ready) begin
        buf_mem[buf_wr] <= byte_shift;
        buf_wr <= ~buf_wr;
      end
      if (buf_pop)
        buf_rd <= ~buf_rd;
      buf_cnt <= buf_cnt + {1'b0, byte_push & buf_in_ready} - {1'b0, buf_pop};
    end
  end

  // Data engine.
  reg  [15:0] access_cnt;
  reg  [9:0]  byte_cnt;
  reg  [2:0]  bit_cnt;
  reg  [4:0]  crc_cnt;
  reg  [1:0]  irq_edge;
  reg         irq_window;
  reg         irq_wide;
  reg         stopping;
  wire [15:0] access_limit = clocked_access_time_field * `SDRD_ACCESS_UNIT
                             + `SDRD_ACCESS_MARGIN; // [RQ7]
  wire        data_start = wide_bus ? (dat_lvl == 4'h0) : ~dat_lvl[0];
  wire        data_tick = rise & ~read_pause_mode; // [RQ12] [RQ13]

  always @(posedge core_clk) begin
    if (reset) begin
      dstate         <= D_IDLE;
      busy           <= 1'b0;
      access_cnt     <= 16'h0;
      byte_cnt       <= 10'h0;
      bit_cnt        <= 3'h0;
      crc_cnt        <= 5'h0;
      byte_shift     <= 8'h00;
      byte_push      <= 1'b0;
      irq_edge       <= 2'h0;
      irq_window     <= 1'b0;
      irq_wide       <= 1'b0;
      stopping       <= 1'b0;
      stop_tail      <= 2'h0;
      access_timeout <= 1'b0;
    end else begin
      if (buf_in_ready)
        byte_push <= 1'b0;
      if (stop_sent) begin
        stopping  <= 1'b1;
        stop_tail <= 2'h0;
      end else if (stopping && rise) begin
        stop_tail <= stop_tail + 2'h1;
        if (stop_tail + 2'h1 == `SDRD_STOP_TAIL) begin // [RQ5]
          stopping <= 1'b0;
          dstate   <= D_IDLE;
          busy     <= 1'b0;
        end
      end
      if (irq_window && data_tick) begin
        irq_edge <= irq_edge + 2'h1;
        if (irq_edge + 2'h1 == `SDRD_IRQ_SAMPLE_EDGE) begin
          irq_wide   <= ~dat_lvl[1]; // [RQ10] [RQ11]
          irq_window <= 1'b0;
        end
      end
      case (dstate)
        D_IDLE: begin
          if (read_start && !busy && cstate == C_IDLE && gap_done) begin
            busy           <= 1'b1;
            access_timeout <= 1'b0;
            access_cnt     <= 16'h0;
            dstate         <= D_WAIT;
          end
        end
        D_WAIT: begin
          if (data_tick && !stopping) begin
            if (data_start) begin // [RQ3] [RQ4]
              byte_cnt <= 10'h0;
              bit_cnt  <= 3'h0;
              dstate   <= D_RX;
            end else if (cstate != C_TX && access_cnt >= access_limit) begin
              access_timeout <= 1'b1;
              busy           <= 1'b0;
              dstate         <= D_IDLE;
            end else if (cstate != C_TX) begin
              access_cnt <= access_cnt + 16'h1;
            end
          end
        end
        D_RX: begin
          if (data_tick && !stopping) begin
            if (wide_bus) begin
              byte_shift <= {byte_shift[3:0], dat_lvl};
              bit_cnt    <= bit_cnt + 3'h4;
            end else begin
              byte_shift <= {byte_shift[6:0], dat_lvl[0]};
              bit_cnt    <= bit_cnt + 3'h1;
            end
            if (bit_cnt == (wide_bus ? 3'h4 : 3'h7)) begin
              byte_push <= 1'b1;
              byte_cnt  <= byte_cnt + 10'h1;
              if (byte_cnt == `SDRD_BLOCK_BYTES - 10'h1) begin
                crc_cnt <= 5'h0;
                dstate  <= D_CRC;
              end
            end
          end
        end
        D_CRC: begin
          if (data_tick && !stopping) begin
            crc_cnt <= crc_cnt + 5'h1;
            if (crc_cnt == `SDRD_CRC_EDGES - 5'h1) begin
              irq_window <= wide_bus; // [RQ11]
              irq_edge   <= 2'h0;
              access_cnt <= 16'h0;
              if (read_multi) begin
                dstate <= D_WAIT; // [RQ4]
              end else begin
                dstate <= D_IDLE;
                busy   <= 1'b0;
              end
            end
          end
        end
        default: dstate <= D_IDLE;
      endcase
    end
  end

  // One-bit mode follows the line directly; the line carries no data there.
  assign card_irq = wide_bus ? irq_wide : ~dat_lvl[1]; // [RQ8] [RQ9]
endmodule // sdrd_host

// *** core/sdrd_defs.vh ***
`ifndef SDRD_DEFS_VH
`define SDRD_DEFS_VH
// Command indices and frame layout.
`define SDRD_CMD_READ_SINGLE  6'h11
`define SDRD_CMD_READ_MULTI   6'h12
`define SDRD_CMD_STOP         6'h0c
`define SDRD_CMD_BITS         6'h30
`define SDRD_CMD_CRC_FIRST    6'h28
`define SDRD_CMD_LAST_BIT     6'h2f
`define SDRD_RSP_LAST_BIT     6'h2f
`define SDRD_CRC7_POLY        7'h09
// Card clock timing.
`define SDRD_GAP_MIN          4'h8
`define SDRD_STOP_TAIL        2'h2
`define SDRD_RSP_LIMIT        7'h40
`define SDRD_ACCESS_UNIT      16'h0064
`define SDRD_ACCESS_MARGIN    16'h0040
// Data block layout.
`define SDRD_BLOCK_BYTES      10'h200
`define SDRD_CRC_EDGES        5'h11
`define SDRD_IRQ_SAMPLE_EDGE  2'h2
`endif

// *** tb/sdrd_host_chk.sv ***
module sdrd_host_chk (
  input logic       core_clk,
  input logic       reset,
  input logic       card_command_line_out,
  input logic       card_command_line_oe,
  input logic [3:0] card_data_in,
  input logic       read_start,
  input logic       wide_bus,
  input logic       read_pause_mode,
  input logic [7:0] read_data,
  input logic       read_valid,
  input logic       read_ready,
  input logic       card_irq,
  input logic       busy
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int FR_MIN = 381;
  localparam int FR_MAX = 387;
  localparam int GAP_MIN = 62;
  logic [9:0] on_len;
  logic [9:0] off_len;
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (reset);
  // The idle count saturates so that a long quiet spell never wraps into a short gap.
  always @(posedge core_clk) begin
    if (reset) off_len <= 10'h3ff;
    else if (card_command_line_oe) off_len <= 10'h000;
    else if (off_len != 10'h3ff) off_len <= off_len + 10'h001;
    if (reset || !card_command_line_oe) on_len <= 10'h000;
    else on_len <= on_len + 10'h001;
  end
  start_busy_a: assert property ($rose(busy) |-> $past(read_start))
    else $error("busy rose without a read request");
  frame_start_a: assert property ($rose(card_command_line_oe) |-> !card_command_line_out)
    else $error("command frame did not open low");
  frame_len_a: assert property ($fell(card_command_line_oe) |->
    on_len >= FR_MIN && on_len <= FR_MAX) else $error("command frame length wrong");
  cmd_gap_a: assert property ($rose(card_command_line_oe) |-> off_len >= GAP_MIN)
    else $error("commands too close together");
  irq_on_a: assert property (!wide_bus && $fell(card_data_in[1]) |-> ##[1:5] card_irq)
    else $error("interrupt not raised");
  irq_off_a: assert property (!wide_bus && $rose(card_data_in[1]) |-> ##[1:5] !card_irq)
    else $error("interrupt not removed");
  valid_hold_a: assert property (read_valid && !read_ready |=>
    read_valid && $stable(read_data)) else $error("stalled byte changed or vanished");
  pause_freeze_a: assert property (read_pause_mode [*8] |-> !$rose(read_valid))
    else $error("byte arrived while paused");
  done_c: cover property ($fell(busy));
  pause_c: cover property (read_pause_mode && busy);
  irq_c: cover property ($rose(card_irq));
endmodule // sdrd_host_chk

bind sdrd_host sdrd_host_chk chk_u (.core_clk(core_clk), .reset(reset),
  .card_command_line_out(card_command_line_out), .card_command_line_oe(card_command_line_oe),
  .card_data_in(card_data_in), .read_start(read_start), .wide_bus(wide_bus),
  .read_pause_mode(read_pause_mode), .read_data(read_data), .read_valid(read_valid),
  .read_ready(read_ready), .card_irq(card_irq), .busy(busy));

// *** tb/sdrd_card.sv ***
`include "sdrd_defs.vh"
module sdrd_card (
  input  logic       card_clk,
  input  logic       cmd_oe,
  input  logic       cmd_out,
  input  logic       pause,
  input  logic       irq_req,
  input  logic       wide,
  input  logic       mute,
  output logic       cmd_in,
  output logic [3:0] dat
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int NAC = 60;
  logic [47:0] sr;
  logic [3:0]  d;
  logic        rdrv, hold, go, multi, stopping;
  // Pull-ups hold both lines high whenever nobody drives them.
  assign cmd_in = cmd_oe ? cmd_out : rdrv;
  assign dat = wide ? d : {d[3:2], d[1] & !irq_req, d[0]};
  always @(posedge card_clk) hold <= pause;
  // A rise the host ignored in pause is not advanced past; one-bit data uses line zero only.
  task automatic step(input logic [3:0] v);
    if (stopping) begin
      d = 4'hf;
      return;
    end
    @(negedge card_clk);
    while (hold) @(negedge card_clk);
    d = stopping ? 4'hf : v;
  endtask
  // In one-bit mode each nibble goes out on line zero, most significant bit first.
  task automatic put(input logic [3:0] v);
    if (wide) begin
      step(v);
    end else begin
      for (int b = 3; b >= 0; b--) step({3'b111, v[b]});
    end
  endtask
  initial begin
    {rdrv, go, stopping, d} = 7'h4f;
    forever begin
      @(posedge card_clk);
      if (cmd_oe && !cmd_out) begin
        repeat (47) begin
          @(posedge card_clk);
          sr = {sr[46:0], cmd_out};
        end
        if (sr[45:40] == `SDRD_CMD_STOP) begin
          fork
            begin
              repeat (2) @(posedge card_clk);
              stopping = 1;
            end
          join_none
        end else begin
          multi = sr[45:40] == `SDRD_CMD_READ_MULTI;
          stopping = 0;
          go = !mute;
        end
        repeat (2) @(negedge card_clk);
        for (int i = 47; i >= 0; i--) begin
          rdrv = i == 0 || (i > 39 && i < 46 && sr[i]);
          @(negedge card_clk);
        end
        rdrv = 1;
      end
    end
  end
  initial begin
    forever begin
      wait (go);
      go = 0;
      do begin
        repeat (NAC) step(4'hf);
        step(wide ? 4'h0 : 4'he);
        for (int i = 0; i < 1024; i++) put(i[0] ? i[4:1] : i[8:5]);
        repeat (16) step(wide ? 4'h0 : 4'he);
        step(4'hf);
        repeat (2) step({2'b11, !irq_req, 1'b1});
        step(4'hf);
      end while (multi && !stopping);
    end
  end
endmodule // sdrd_card

// *** tb/sdrd_host_test.sv ***
`include "sdrd_defs.vh"
module sdrd_host_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic        core_clk, reset, card_clk, cmd_in, cmd_out, cmd_oe, read_start, multi, wide;
  logic        pause, stop_req, ready, rvalid, clk_run, irq, busy, acc_to, rsp_to, irq_req;
  logic        mute;
  logic [7:0]  acc_field;
  logic [3:0]  dat;
  logic [31:0] addr;
  logic [7:0]  rdata, exp_b;
  logic [47:0] fr;
  int          failures, n_tests;
  sdrd_host dut_u (.core_clk(core_clk), .reset(reset), .card_clk(card_clk),
    .card_command_line_in(cmd_in), .card_command_line_out(cmd_out),
    .card_command_line_oe(cmd_oe), .card_data_in(dat), .read_start(read_start),
    .read_address(addr), .read_multi(multi), .wide_bus(wide),
    .clocked_access_time_field(acc_field), .read_pause_mode(pause), .stop_request(stop_req),
    .read_data(rdata), .read_valid(rvalid), .read_ready(ready), .card_clk_run(clk_run),
    .card_irq(irq), .busy(busy), .access_timeout(acc_to), .response_timeout(rsp_to));
  sdrd_card card_u (.card_clk(card_clk), .cmd_oe(cmd_oe), .cmd_out(cmd_out), .pause(pause),
    .irq_req(irq_req), .wide(wide), .mute(mute), .cmd_in(cmd_in), .dat(dat));
  initial begin
    core_clk = 0;
    forever #25 core_clk = ~core_clk;
  end
  // The card clock parks low while the host asks for a stall.
  initial begin
    card_clk = 0;
    #13;
    forever begin
      #200;
      if (card_clk || clk_run !== 1'b0) card_clk = ~card_clk;
    end
  end
  always @(posedge card_clk) if (cmd_oe) fr <= {fr[46:0], cmd_out};
  task automatic tick();
    @(posedge core_clk);
    #1;
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic await(ref logic s, input logic v, input int lim);
    int w;
    w = 0;
    while (s !== v && w < lim) begin
      tick();
      w++;
    end
    check("awaited level", s, v);
  endtask
  task automatic take(input int n);
    repeat (n) begin
      await(rvalid, 1'b1, 3000);
      check("read_data", rdata, exp_b);
      exp_b++;
      tick();
    end
  endtask
  task automatic set_pause(input logic v);
    @(negedge card_clk);
    tick();
    pause = v;
  endtask
  task automatic read_cmd(input logic m, input logic [31:0] a, input logic [5:0] idx);
    // Let an earlier response and the command gap run out, or the start is ignored.
    repeat (600) tick();
    multi = m;
    addr = a;
    exp_b = 0;
    read_start = 1;
    tick();
    read_start = 0;
    await(busy, 1'b1, 4);
    await(cmd_oe, 1'b1, 40);
    await(cmd_oe, 1'b0, 500);
    check("cmd_index", fr[45:40], idx);
    check("cmd_arg", fr[39:8], a);
  endtask
  task automatic t_irq_one_bit();
    irq_req = 1;
    repeat (8) tick();
    check("irq_line_low", irq, 1);
    irq_req = 0;
    repeat (8) tick();
    check("irq_line_high", irq, 0);
    $display("one-bit interrupt test done");
  endtask
  task automatic t_narrow();
    wide = 0;
    irq_req = 0;
    read_cmd(1, 32'h0000_0800, `SDRD_CMD_READ_MULTI);
    take(16);
    check("irq_data_phase", irq, 0);
    stop_req = 1;
    tick();
    stop_req = 0;
    await(cmd_oe, 1'b1, 200);
    await(cmd_oe, 1'b0, 500);
    check("narrow_stop_index", fr[45:40], `SDRD_CMD_STOP);
    await(busy, 1'b0, 40);
    $display("one-bit multi block test done");
  endtask
  task automatic t_timeout();
    mute = 1;
    acc_field = 8'h02;
    read_cmd(0, 32'h0000_2000, `SDRD_CMD_READ_SINGLE);
    repeat (8 * (2 * `SDRD_ACCESS_UNIT + `SDRD_ACCESS_MARGIN) - 4) tick();
    check("access_early", acc_to, 0);
    await(acc_to, 1'b1, 16);
    check("busy_after_timeout", busy, 0);
    mute = 0;
    $display("access timeout test done");
  endtask
  task automatic t_single();
    wide = 1;
    read_cmd(0, 32'h0000_0400, `SDRD_CMD_READ_SINGLE);
    take(10);
    ready = 0;
    repeat (300) tick();
    check("clk_run_stall", clk_run, 0);
    ready = 1;
    take(502);
    await(busy, 1'b0, 400);
    repeat (40) tick();
    check("irq_period_clear", irq, 0);
    check("timeouts", {acc_to, rsp_to}, 0);
    $display("single block test done");
  endtask
  task automatic t_multi();
    irq_req = 1;
    read_cmd(1, 32'h0000_1000, `SDRD_CMD_READ_MULTI);
    take(100);
    check("irq_mid_block", irq, 0);
    set_pause(1);
    repeat (16) tick();
    while (rvalid === 1'b1) take(1);
    repeat (160) tick();
    check("paused_valid", rvalid, 0);
    set_pause(0);
    take(500);
    check("irq_period_set", irq, 1);
    stop_req = 1;
    tick();
    stop_req = 0;
    await(cmd_oe, 1'b1, 200);
    await(cmd_oe, 1'b0, 500);
    check("stop_index", fr[45:40], `SDRD_CMD_STOP);
    await(busy, 1'b0, 40);
    while (rvalid === 1'b1) take(1);
    repeat (100) tick();
    check("data_ended", rvalid, 0);
    $display("multi block stop and pause test done");
  endtask
  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge core_clk);
    failures++;
    print_verdict();
  end
  initial begin
    reset = 1;
    {read_start, multi, wide, pause, stop_req, irq_req} = 6'h00;
    mute = 1'b0;
    acc_field = 8'h01;
    ready = 1;
    addr = 32'h0000_0000;
    repeat (10) tick();
    reset = 0;
    repeat (4) tick();
    t_irq_one_bit();
    t_narrow();
    t_single();
    t_multi();
    t_timeout();
    print_verdict();
  end
endmodule // sdrd_host_test
